/* reset_cause_regs.svh */
`ifndef RESET_CAUSE_REGS_SVH
`define RESET_CAUSE_REGS_SVH

// Register byte offsets on the APB slave.
`define RC_OFF_STATUS_0   8'h00
`define RC_OFF_STATUS_1   8'h04
`define RC_OFF_STATUS_2   8'h08
`define RC_OFF_EVENT      8'h0C
`define RC_OFF_MASK       8'h10
`define RC_OFF_TRACK      8'h14

// Field positions in reset_status_0.
`define RC_S0_POWER_ON    0
`define RC_S0_VMON0       1
`define RC_S0_VMON1       2
`define RC_S0_VMON2       3
`define RC_S0_DEEP_STBY   7
// Field position in reset_status_1.
`define RC_S1_COLD_WARM   0
// Field positions in reset_status_2.
`define RC_S2_INDEP_WDOG  0
`define RC_S2_WDOG        1
`define RC_S2_SOFTWARE    2

// Event register width and the interval-done event bit.
`define RC_EVT_W          10
`define RC_EVT_DONE       9
// Flag bits that can raise an event (cold/warm bit excluded).
`define RC_EVT_FLAG_MASK  9'h1F7

// Reset values: flags and seen are applied by the power-on reset, mask and event by the system reset.
`define RC_FLAGS_POR      9'h100
`define RC_SEEN_POR       9'h080
`define RC_MASK_RST       10'h000
`define RC_EVENT_RST      10'h000

`endif

/* reset_cause_pkg.sv */
package reset_cause_pkg;

  // Reset cause flags, most significant field first.
  typedef struct packed {
    logic power_on_detect_flag;
    logic vmon0_detect_flag;
    logic vmon1_detect_flag;
    logic vmon2_detect_flag;
    logic deep_standby_cancel_flag;
    logic cold_warm_start_flag;
    logic indep_watchdog_detect_flag;
    logic watchdog_detect_flag;
    logic software_reset_flag;
  } rst_flags_t;

  // Synchronous reset requests from on-chip sources.
  typedef struct packed {
    logic vmon0;
    logic vmon1;
    logic vmon2;
    logic deep_standby;
    logic indep_watchdog;
    logic watchdog;
    logic software;
  } rst_req_t;

  // Sources seen during one reset interval.
  typedef struct packed {
    logic pin;
    logic power_on;
    logic vmon0;
    logic vmon1;
    logic vmon2;
    logic deep_standby;
    logic indep_watchdog;
    logic watchdog;
    logic software;
  } rst_seen_t;

  // Reset interval tracker states.
  typedef enum logic {
    TRK_QUIET,
    TRK_ACTIVE
  } trk_state_t;

endpackage

/* reset_cause_flag_logic.sv */

`timescale 1ns/1ps
`include "reset_cause_regs.svh"

module reset_cause_flag_logic (
  input  wire logic                      pclk,                 // APB clock, 10 MHz.
  input  wire logic                      presetn,              // System reset, async, active low.
  input  wire logic                      por_n,                // Power-on reset, async, active low.
  input  wire logic                      external_reset_pin_n, // Reset pin level, low is active.
  input  wire reset_cause_pkg::rst_req_t reset_req,            // Other reset source requests.
  input  wire logic                      psel,                 // APB select.
  input  wire logic                      penable,              // APB enable.
  input  wire logic                      pwrite,               // APB direction, high writes.
  input  wire logic [7:0]                paddr,                // APB byte address.
  input  wire logic [31:0]               pwdata,               // APB write data.
  output logic      [31:0]               prdata,               // APB read data.
  output logic                           pready,               // APB ready.
  output logic                           pslverr,              // APB error on unmapped address.
  output reset_cause_pkg::rst_flags_t    flags,                // Current reset cause flags.
  output logic                           interval_active,      // A reset interval is open.
  output logic                           irq                   // Level interrupt.
);
  import reset_cause_pkg::*;

  // Flag domain state.
  // It follows only the power-on reset, never the system reset.
  trk_state_t state;
  trk_state_t next_state;
  rst_seen_t  seen;
  rst_seen_t  next_seen;
  rst_seen_t  cur;
  rst_flags_t next_flags;
  rst_flags_t res;
  logic       any_active;
  logic       commit;
  logic       cold_warm_start_flag_set;

  // Bus domain state.
  // Everything here follows the system reset.
  logic [`RC_EVT_W-1:0] event_st;
  logic [`RC_EVT_W-1:0] next_event_st;
  logic [`RC_EVT_W-1:0] evt_set;
  logic [`RC_EVT_W-1:0] mask;
  logic [`RC_EVT_W-1:0] next_mask;
  logic [31:0]          next_prdata;
  logic [31:0]          rd_mux;
  logic                 setup;
  logic                 access;
  logic                 addr_hit;
  logic                 evt_read;

  // Sources active in this cycle. The power-on source is not sampled here:
  // its asynchronous reset already holds the whole flag domain.
  // The pin is active low, so its level is inverted into the active set.
  always_comb begin
    cur                = '0;
    cur.pin            = ~external_reset_pin_n;
    cur.vmon0          = reset_req.vmon0;
    cur.vmon1          = reset_req.vmon1;
    cur.vmon2          = reset_req.vmon2;
    cur.deep_standby   = reset_req.deep_standby;
    cur.indep_watchdog = reset_req.indep_watchdog;
    cur.watchdog       = reset_req.watchdog;
    cur.software       = reset_req.software;
    any_active         = |cur;
  end

  // Outcome of the interval. Sources are applied from the weakest to the
  // strongest, so from deep-standby cancel up a stronger source wipes whatever
  // a weaker one set, in whatever order they arrived inside the interval.
  // The pin is applied last: it is the only source that clears the
  // power-on flag, so a pin pulse inside a power-on interval still wins.
  always_comb begin
    // Start from the committed flags so untouched fields keep their values.
    res = flags;
    // Watchdog and software sources only set their own flags.
    if (seen.software) begin
      res.software_reset_flag = 1'b1;
    end
    if (seen.watchdog) begin
      res.watchdog_detect_flag = 1'b1;
    end
    if (seen.indep_watchdog) begin
      res.indep_watchdog_detect_flag = 1'b1;
    end
    // Deep-standby cancel clears the watchdog and software flags.
    if (seen.deep_standby) begin
      res.indep_watchdog_detect_flag = 1'b0;
      res.watchdog_detect_flag       = 1'b0;
      res.software_reset_flag        = 1'b0;
      res.deep_standby_cancel_flag   = 1'b1;
    end
    // Vmon2 clears every flag weaker than itself.
    if (seen.vmon2) begin
      res.deep_standby_cancel_flag   = 1'b0;
      res.indep_watchdog_detect_flag = 1'b0;
      res.watchdog_detect_flag       = 1'b0;
      res.software_reset_flag        = 1'b0;
      res.vmon2_detect_flag          = 1'b1;
    end
    // Vmon1 clears every flag weaker than itself.
    if (seen.vmon1) begin
      res.vmon2_detect_flag          = 1'b0;
      res.deep_standby_cancel_flag   = 1'b0;
      res.indep_watchdog_detect_flag = 1'b0;
      res.watchdog_detect_flag       = 1'b0;
      res.software_reset_flag        = 1'b0;
      res.vmon1_detect_flag          = 1'b1;
    end
    // Vmon0 leaves power-on and cold/warm flags alone.
    if (seen.vmon0) begin
      res.vmon1_detect_flag          = 1'b0;
      res.vmon2_detect_flag          = 1'b0;
      res.deep_standby_cancel_flag   = 1'b0;
      res.indep_watchdog_detect_flag = 1'b0;
      res.watchdog_detect_flag       = 1'b0;
      res.software_reset_flag        = 1'b0;
      res.vmon0_detect_flag          = 1'b1;
    end
    // Power-on clears all other detect flags and the cold/warm flag.
    // The whole word is loaded first, then the two named fields are spelled
    // out so the intent of each stays visible.
    if (seen.power_on) begin
      res                      = `RC_FLAGS_POR;
      res.cold_warm_start_flag = 1'b0;
      res.power_on_detect_flag = 1'b1;
    end
    // The pin clears every detect flag but never the cold/warm flag.
    // A pin held through a power-on still clears the power-on flag.
    if (seen.pin) begin
      res.power_on_detect_flag       = 1'b0;
      res.vmon0_detect_flag          = 1'b0;
      res.vmon1_detect_flag          = 1'b0;
      res.vmon2_detect_flag          = 1'b0;
      res.deep_standby_cancel_flag   = 1'b0;
      res.indep_watchdog_detect_flag = 1'b0;
      res.watchdog_detect_flag       = 1'b0;
      res.software_reset_flag        = 1'b0;
    end
  end

  // Interval tracker. Flags stay frozen while any source is active and
  // take the accumulated outcome in the cycle the last one releases.
  always_comb begin
    next_state = state;
    next_seen  = seen;
    next_flags = flags;
    commit     = 1'b0;
    case (state)
      TRK_QUIET: begin
        // The first active source opens an interval.
        if (any_active) begin
          next_state = TRK_ACTIVE;
          next_seen  = cur;
        end
      end
      TRK_ACTIVE: begin
        if (any_active) begin
          next_seen = seen | cur;
        end else begin
          // The last source has released: commit and start afresh.
          next_state = TRK_QUIET;
          next_flags = res;
          next_seen  = '0;
          commit     = 1'b1;
        end
      end
      default: begin
        // An illegal state falls back to quiet.
        next_state = TRK_QUIET;
      end
    endcase
    // Software may mark a warm start only outside a reset interval.
    // Refusing it while a source is active keeps a write that races a
    // reset from leaking into the committed flags.
    if (cold_warm_start_flag_set && state == TRK_QUIET && !any_active) begin
      next_flags.cold_warm_start_flag = 1'b1;
    end
  end

  // The flag domain is reset only by power-on, never by the system reset,
  // so flags survive every reset that is not meant to clear them.
  // The tracker wakes in the active state with power-on already seen, so
  // the first quiet edge after power-on commits its outcome.
  always_ff @(posedge pclk or negedge por_n) begin
    if (!por_n) begin
      state <= TRK_ACTIVE;
      seen  <= `RC_SEEN_POR;
      flags <= `RC_FLAGS_POR;
    end else begin
      state <= next_state;
      seen  <= next_seen;
      flags <= next_flags;
    end
  end

  // Software and the bench see an open interval through this level.
  // It is decoded from the state register, so it moves only after an edge.
  assign interval_active = (state == TRK_ACTIVE);

  // APB phase decode; the slave answers in the first access cycle.
  // Zero wait states keep the slave simple, at the cost of a combinational
  // ready path from psel and penable.
  always_comb begin
    setup  = psel & ~penable;
    access = psel & penable;
    pready = access;
    // Only the six mapped offsets answer without an error.
    case (paddr)
      `RC_OFF_STATUS_0,
      `RC_OFF_STATUS_1,
      `RC_OFF_STATUS_2,
      `RC_OFF_EVENT,
      `RC_OFF_MASK,
      `RC_OFF_TRACK: addr_hit = 1'b1;
      default:       addr_hit = 1'b0;
    endcase
    pslverr  = access & ~addr_hit;
    evt_read = access & ~pwrite & (paddr == `RC_OFF_EVENT);
    cold_warm_start_flag_set = access & pwrite & (paddr == `RC_OFF_STATUS_1) & pwdata[`RC_S1_COLD_WARM];
  end

  // Read multiplexer. Reserved bits read as zero.
  // The track register shows the sources gathered so far, which helps when
  // a reset is still held.
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (paddr)
      `RC_OFF_STATUS_0: begin
        rd_mux[`RC_S0_POWER_ON]  = flags.power_on_detect_flag;
        rd_mux[`RC_S0_VMON0]     = flags.vmon0_detect_flag;
        rd_mux[`RC_S0_VMON1]     = flags.vmon1_detect_flag;
        rd_mux[`RC_S0_VMON2]     = flags.vmon2_detect_flag;
        rd_mux[`RC_S0_DEEP_STBY] = flags.deep_standby_cancel_flag;
      end
      `RC_OFF_STATUS_1: begin
        rd_mux[`RC_S1_COLD_WARM] = flags.cold_warm_start_flag;
      end
      `RC_OFF_STATUS_2: begin
        rd_mux[`RC_S2_INDEP_WDOG] = flags.indep_watchdog_detect_flag;
        rd_mux[`RC_S2_WDOG]       = flags.watchdog_detect_flag;
        rd_mux[`RC_S2_SOFTWARE]   = flags.software_reset_flag;
      end
      `RC_OFF_EVENT: begin
        rd_mux[`RC_EVT_W-1:0] = event_st;
      end
      `RC_OFF_MASK: begin
        rd_mux[`RC_EVT_W-1:0] = mask;
      end
      `RC_OFF_TRACK: begin
        rd_mux[0]    = interval_active;
        rd_mux[12:4] = seen;
      end
      default: begin
        rd_mux = 32'h0000_0000;
      end
    endcase
  end

  // Events: each flag that rises at a commit, plus the commit itself.
  // A read of the event register clears it, but a new event in the access
  // cycle wins; one raised in the setup cycle is cleared without being read.
  // The cold/warm bit never raises an event: only software sets it.
  always_comb begin
    evt_set                = '0;
    evt_set[8:0]           = commit ? (res & ~flags & `RC_EVT_FLAG_MASK) : 9'h000;
    evt_set[`RC_EVT_DONE]  = commit;
    next_event_st          = evt_read ? evt_set : (event_st | evt_set);
    // Mask writes land at the access edge, as every write does.
    next_mask              = mask;
    if (access && pwrite && paddr == `RC_OFF_MASK) begin
      next_mask = pwdata[`RC_EVT_W-1:0];
    end
    next_prdata = setup ? rd_mux : prdata;
  end

  // Bus-side registers follow the system reset.
  // A system reset drops pending events and the mask; the flags are
  // untouched, so firmware can still read the cause afterwards.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      event_st <= `RC_EVENT_RST;
      mask     <= `RC_MASK_RST;
      prdata   <= 32'h0000_0000;
    end else begin
      event_st <= next_event_st;
      mask     <= next_mask;
      prdata   <= next_prdata;
    end
  end

  // Interrupt stays high while any unmasked event bit is set.
  // It depends on registers only, so it changes just after a clock edge.
  assign irq = |(event_st & mask);

endmodule

/* rc_flag_asserts.sv */
`timescale 1ns/1ps
module rc_flag_asserts (
  input wire logic                        pclk, // Bus clock.
  input wire logic                        presetn, // Bus reset.
  input wire logic                        por_n, // Power-on reset.
  input wire logic                        external_reset_pin_n, // Reset pin.
  input wire reset_cause_pkg::rst_req_t   reset_req, // Source requests.
  input wire logic                        psel, // Select.
  input wire logic                        penable, // Enable.
  input wire logic                        pwrite, // Direction.
  input wire logic [7:0]                  paddr, // Address.
  input wire logic                        pready, // Ready.
  input wire logic                        pslverr, // Error.
  input wire reset_cause_pkg::rst_flags_t flags, // Cause flags.
  input wire logic                        interval_active, // Interval open.
  input wire logic                        irq // Interrupt.
);
  import reset_cause_pkg::*;
  logic acc;
  logic idle;
  logic cw_wr;
  // Access phase, a cold/warm write, and the no-source condition that closes an interval.
  assign acc = psel && penable;
  assign idle = external_reset_pin_n && reset_req == 7'h00;
  assign cw_wr = acc && pwrite && paddr == 8'h04;
  // A power-on reset makes every earlier sample meaningless, so both resets disable.
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!por_n || !presetn);
  property p_slverr;
    acc && paddr > 8'h14 |-> pready && pslverr;
  endproperty
  a_slverr: assert property (p_slverr) else $error("unmapped access not refused");
  property p_quiet;
    !acc |-> !pready && !pslverr;
  endproperty
  a_quiet: assert property (p_quiet) else $error("answer outside access phase");
  property p_frozen;
    !idle |=> $stable(flags);
  endproperty
  a_frozen: assert property (p_frozen) else $error("flags moved while a source acts");
  property p_open;
    !idle |=> interval_active;
  endproperty
  a_open: assert property (p_open) else $error("interval not open");
  property p_close;
    interval_active && idle |=> !interval_active;
  endproperty
  a_close: assert property (p_close) else $error("interval not closed");
  property p_pin_clr;
    !external_reset_pin_n ##1 idle |=> (flags & 9'h1F7) == 9'h000;
  endproperty
  a_pin_clr: assert property (p_pin_clr) else $error("pin reset left a flag set");
  property p_vmon0;
    !interval_active && external_reset_pin_n && reset_req == 7'h40 ##1 idle
      |=> flags.vmon0_detect_flag && (flags & 9'h077) == 9'h000;
  endproperty
  a_vmon0: assert property (p_vmon0) else $error("vmon0 flags wrong");
  property p_por;
    $rose(por_n) && idle |=> flags == 9'h100;
  endproperty
  a_por: assert property (p_por) else $error("power-on flags wrong");
  property p_hold;
    $changed(flags) |-> $past(interval_active) || $past(cw_wr);
  endproperty
  a_hold: assert property (p_hold) else $error("flags changed with no cause");
  property p_irq_clr;
    acc && !pwrite && paddr == 8'h0C && !interval_active |=> !irq;
  endproperty
  a_irq_clr: assert property (p_irq_clr) else $error("event read left irq high");
  c_pin: cover property (!external_reset_pin_n ##1 idle);
  c_vmon0: cover property (reset_req == 7'h40 ##1 idle);
  c_irq: cover property ($rose(irq));
endmodule

bind reset_cause_flag_logic rc_flag_asserts rc_flag_asserts_i (.*);

/* tb.sv */
`timescale 1ns/1ps
`include "reset_cause_regs.svh"
module tb;
  import reset_cause_pkg::*;
  logic        pclk = 1'b0, presetn = 1'b0, por_n = 1'b0, external_reset_pin_n = 1'b1;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, slverr, interval_active, irq;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  rst_req_t    reset_req = 7'h00;
  rst_flags_t  flags, keep;
  rst_req_t    srcs[3] = '{7'h01, 7'h02, 7'h04};
  int          err_count = 0, check_count = 0;
  reset_cause_flag_logic reset_cause_flag_logic_i (.*);
  // Half period of 50 ns gives the 10 MHz bus clock.
  always #50 pclk = ~pclk;
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic final_report();
    $display("Mismatches %0d, comparisons %0d", err_count, check_count);
    if (err_count == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // One transfer; the request stands until pready is seen at a rising edge.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      err_count++;
      final_report();
    end
    r = prdata;
    slverr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0, rd);
    chk(rd, e);
  endtask
  // Waits for the interval to close; a stuck interval ends the run.
  task automatic settle();
    int n;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (interval_active !== 1'b0 && n < 50);
    if (interval_active !== 1'b0) begin
      err_count++;
      final_report();
    end
  endtask
  task automatic pulse(input rst_req_t q);
    reset_req <= q;
    @(posedge pclk);
    reset_req <= 7'h00;
    settle();
  endtask
  // Each step sets up flags that the next reset must keep or clear.
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    por_n <= 1'b1;
    settle();
    rchk(`RC_OFF_STATUS_0, 32'h1);
    rchk(`RC_OFF_STATUS_1, 32'h0);
    rchk(`RC_OFF_EVENT, 32'h200);
    rchk(`RC_OFF_EVENT, 32'h0);
    apb(1'b0, 8'h20, 32'h0, rd);
    chk({31'h0, slverr}, 32'h1);
    apb(1'b1, `RC_OFF_MASK, 32'h200, rd);
    rchk(`RC_OFF_MASK, 32'h200);
    foreach (srcs[i]) pulse(srcs[i]);
    chk({31'h0, irq}, 32'h1);
    apb(1'b0, `RC_OFF_EVENT, 32'h0, rd);
    chk(rd & 32'h200, 32'h200);
    @(posedge pclk);
    chk({31'h0, irq}, 32'h0);
    rchk(`RC_OFF_STATUS_2, 32'h7);
    // Deep-standby cancel clears the watchdog and software flags.
    pulse(7'h08);
    rchk(`RC_OFF_STATUS_0, 32'h81);
    rchk(`RC_OFF_STATUS_2, 32'h0);
    apb(1'b1, `RC_OFF_STATUS_1, 32'h1, rd);
    pulse(7'h40);
    rchk(`RC_OFF_STATUS_0, 32'h3);
    rchk(`RC_OFF_STATUS_1, 32'h1);
    rchk(`RC_OFF_STATUS_2, 32'h0);
    // Vmon2 then vmon1: each sets its own flag, vmon1 clears vmon2.
    pulse(7'h10);
    rchk(`RC_OFF_STATUS_0, 32'hB);
    pulse(7'h20);
    rchk(`RC_OFF_STATUS_0, 32'h7);
    keep = flags;
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk({23'h0, flags}, {23'h0, keep});
    reset_req <= 7'h40;
    @(posedge pclk);
    external_reset_pin_n <= 1'b0;
    repeat (2) @(posedge pclk);
    reset_req <= 7'h00;
    repeat (2) @(posedge pclk);
    chk({23'h0, flags}, {23'h0, keep});
    external_reset_pin_n <= 1'b1;
    settle();
    rchk(`RC_OFF_STATUS_0, 32'h0);
    rchk(`RC_OFF_STATUS_1, 32'h1);
    pulse(7'h01);
    reset_req <= 7'h40;
    @(posedge pclk);
    por_n <= 1'b0;
    @(posedge pclk);
    reset_req <= 7'h00;
    @(posedge pclk);
    por_n <= 1'b1;
    settle();
    rchk(`RC_OFF_STATUS_0, 32'h1);
    rchk(`RC_OFF_STATUS_1, 32'h0);
    rchk(`RC_OFF_STATUS_2, 32'h0);
    apb(1'b1, `RC_OFF_STATUS_1, 32'h1, rd);
    pulse(7'h01);
    por_n <= 1'b0;
    @(posedge pclk);
    external_reset_pin_n <= 1'b0;
    @(posedge pclk);
    por_n <= 1'b1;
    @(posedge pclk);
    external_reset_pin_n <= 1'b1;
    settle();
    rchk(`RC_OFF_STATUS_0, 32'h0);
    rchk(`RC_OFF_STATUS_1, 32'h0);
    rchk(`RC_OFF_STATUS_2, 32'h0);
    final_report();
  end
endmodule
